/* rtl/compact_timer_pkg.sv */
`default_nettype none
package compact_timer_pkg;

	localparam int DATA_W = 32;
	localparam int ADDR_W = 6;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL0  = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_CTRL1  = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_COUNT  = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_ACMP   = 6'h0c;
	localparam logic [ADDR_W-1:0] OFS_PCMP   = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_MASK   = 6'h18;

	// Control 0 fields
	localparam int C0_PAUSE   = 7;
	localparam int C0_CLK_LO  = 4;
	localparam int C0_ENABLE  = 3;
	// Control 1 fields (timer_control_one)
	localparam int C1_MODE_LO = 6;
	localparam int C1_OUTF_LO = 4;
	localparam int C1_INIT    = 3;
	localparam int C1_POL     = 2;
	localparam int C1_SWAP    = 1;
	localparam int C1_CLRSEL  = 0;
	// Status / mask fields
	localparam int ST_A       = 0;
	localparam int ST_P       = 1;

	localparam logic [7:0]  CTRL_RESET  = 8'h00;
	localparam logic [15:0] CNT_MAX     = 16'hffff;
	localparam logic [15:0] CNT_ZERO    = 16'h0000;
	localparam logic [7:0]  PCMP_ZERO   = 8'h00;
	localparam logic [16:0] FULL_PERIOD = 17'h10000;

	localparam logic [1:0] MODE_CMP = 2'h0;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TMR = 2'h3;

	localparam logic [1:0] OF_NONE  = 2'h0;
	localparam logic [1:0] OF_LOW   = 2'h1;
	localparam logic [1:0] OF_HIGH  = 2'h2;
	localparam logic [1:0] OF_TOG   = 2'h3;
	localparam logic [1:0] PF_INACT = 2'h0;
	localparam logic [1:0] PF_ACT   = 2'h1;
	localparam logic [1:0] PF_PWM   = 2'h2;

	// Clock select codes
	localparam logic [2:0] CK_SYS4  = 3'h0;
	localparam logic [2:0] CK_SYS   = 3'h1;
	localparam logic [2:0] CK_H16   = 3'h2;
	localparam logic [2:0] CK_H64   = 3'h3;
	localparam logic [2:0] CK_SUB0  = 3'h4;
	localparam logic [2:0] CK_SUB1  = 3'h5;
	localparam logic [2:0] CK_EXTR  = 3'h6;
	localparam logic [2:0] CK_EXTF  = 3'h7;
	localparam int         DIV_W    = 6;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b01,
		WR_RESP = 2'b10
	} wr_state_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_DATA = 2'b10
	} rd_state_t;

endpackage : compact_timer_pkg

`default_nettype wire

/* rtl/compact_timer.sv */
`timescale 1ns/10ps
`default_nettype none

module compact_timer
	import compact_timer_pkg::*;
#(
	parameter int H_DIV   = 1,
	parameter int SUB_DIV = 32
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              ext_clk_in,
	output logic                   timer_out,
	output logic                   irq
);

	initial begin
		if (H_DIV < 1 || H_DIV > 4 || SUB_DIV < 1 || SUB_DIV > 64)
			$error("compact_timer: divider parameter out of range");
	end

	typedef struct packed {
		wr_state_t         wst;
		rd_state_t         rst;
		logic              aw_got;
		logic              w_got;
		logic [ADDR_W-1:0] awaddr;
		logic [DATA_W-1:0] wdata;
		logic [3:0]        wstrb;
		logic [1:0]        bresp;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
		logic [7:0]        ctrl0;
		logic [7:0]        ctrl1;
		logic [15:0]       acmp;
		logic [7:0]        pcmp;
		logic [1:0]        status;
		logic [1:0]        mask;
		logic [15:0]       cnt;
		logic              en_d;
		logic              pin;
		logic              out;
		logic              irq;
		logic [DIV_W-1:0]  div;
		logic [DIV_W-1:0]  hdiv;
		logic [DIV_W-1:0]  sdiv;
		logic              ext_d;
		logic              aw_rdy;
		logic              w_rdy;
		logic              b_vld;
		logic              ar_rdy;
		logic              r_vld;
	} state_t;

	state_t q_r, q_nxt;

	function automatic logic [7:0] merge8(input logic [7:0] old, input logic [DATA_W-1:0] d, input logic s);
		merge8 = s ? d[7:0] : old;
	endfunction : merge8

	logic [1:0]  mode;
	logic [1:0]  ofun;
	logic        enable;
	logic        tick;
	logic        a_hit;
	logic        p_hit;
	logic [16:0] period;
	logic [16:0] duty;
	logic        pwm_act;
	logic        lvl;
	logic [2:0]  cksel;
	logic        wr_go;
	logic        ovf;

	always_comb begin
		q_nxt  = q_r;
		mode   = q_r.ctrl1[C1_MODE_LO +: 2];
		ofun   = q_r.ctrl1[C1_OUTF_LO +: 2];
		enable = q_r.ctrl0[C0_ENABLE];
		cksel  = q_r.ctrl0[C0_CLK_LO +: 3];

		// Prescalers; f_H and f_SUB are modelled as divided system clock
		q_nxt.div   = DIV_W'(q_r.div + 1'b1);
		q_nxt.ext_d = ext_clk_in;
		q_nxt.hdiv  = (q_r.hdiv == DIV_W'(H_DIV - 1)) ? '0 : DIV_W'(q_r.hdiv + 1'b1);
		q_nxt.sdiv  = (q_r.sdiv == DIV_W'(SUB_DIV - 1)) ? '0 : DIV_W'(q_r.sdiv + 1'b1);
		case (cksel)
			CK_SYS4: tick = (q_r.div[1:0] == 2'h3);
			CK_SYS:  tick = 1'b1;
			CK_H16:  tick = (q_r.hdiv == '0) && (q_r.div[3:0] == 4'hf);
			CK_H64:  tick = (q_r.hdiv == '0) && (q_r.div == 6'h3f);
			CK_SUB0, CK_SUB1: tick = (q_r.sdiv == '0);
			CK_EXTR: tick = ext_clk_in && !q_r.ext_d;
			CK_EXTF: tick = !ext_clk_in && q_r.ext_d;
			default: tick = 1'b0;
		endcase
		tick = tick && enable && !q_r.ctrl0[C0_PAUSE];

		a_hit = tick && (q_r.acmp != CNT_ZERO) && (q_r.cnt == q_r.acmp);
		// Period n ends at count n*256-1, so the clear gives n*256 clocks
		p_hit = tick && (q_r.pcmp == PCMP_ZERO ? q_r.cnt == CNT_MAX
			: (q_r.cnt[15:8] == 8'(q_r.pcmp - 1'b1) && q_r.cnt[7:0] == 8'hff));
		ovf   = tick && (q_r.cnt == CNT_MAX);

		// Period/duty selection
		if (q_r.ctrl1[C1_SWAP]) begin
			period = (q_r.acmp == CNT_ZERO) ? FULL_PERIOD : {1'b0, q_r.acmp};
			duty   = (q_r.pcmp == PCMP_ZERO) ? FULL_PERIOD : {1'b0, q_r.pcmp, 8'h00};
		end else begin
			period = (q_r.pcmp == PCMP_ZERO) ? FULL_PERIOD : {1'b0, q_r.pcmp, 8'h00};
			duty   = {1'b0, q_r.acmp};
		end
		pwm_act = ({1'b0, q_r.cnt} < duty) || (duty >= period);

		// Counter
		if (enable && !q_r.en_d) begin
			q_nxt.cnt = CNT_ZERO;
		end else if (tick) begin
			if (mode == MODE_PWM) begin
				// Clear at end of period, clear-select ignored
				if ({1'b0, q_r.cnt} == 17'(period - 1'b1))
					q_nxt.cnt = CNT_ZERO;
				else
					q_nxt.cnt = 16'(q_r.cnt + 1'b1);
			end else if (q_r.ctrl1[C1_CLRSEL]) begin
				q_nxt.cnt = (a_hit || ovf) ? CNT_ZERO : 16'(q_r.cnt + 1'b1);
			end else begin
				q_nxt.cnt = (p_hit || ovf) ? CNT_ZERO : 16'(q_r.cnt + 1'b1);
			end
		end
		q_nxt.en_d = enable;

		// Flags: set wins over software clear
		if (mode == MODE_PWM) begin
			if (q_r.ctrl1[C1_SWAP]) begin
				lvl   = ({1'b0, q_r.cnt} == 17'(period - 1'b1));
				a_hit = tick && lvl;
				p_hit = tick && ({1'b0, q_r.cnt} == 17'(duty - 1'b1));
			end else begin
				lvl   = 1'b0;
				a_hit = tick && (q_r.cnt == q_r.acmp);
			end
		end else begin
			lvl = 1'b0;
			if (q_r.ctrl1[C1_CLRSEL])
				p_hit = 1'b0;
		end
		if (q_r.wst == WR_IDLE && q_r.aw_got && q_r.w_got && q_r.awaddr == OFS_STATUS && q_r.wstrb[0])
			q_nxt.status = q_r.status & ~q_r.wdata[1:0];
		if (a_hit)
			q_nxt.status[ST_A] = 1'b1;
		if (p_hit)
			q_nxt.status[ST_P] = 1'b1;

		// Output pin
		q_nxt.pin = q_r.pin;
		if (enable && !q_r.en_d) begin
			q_nxt.pin = q_r.ctrl1[C1_INIT];
		end else if (mode == MODE_CMP && a_hit) begin
			case (ofun)
				OF_LOW:  q_nxt.pin = 1'b0;
				OF_HIGH: q_nxt.pin = 1'b1;
				OF_TOG:  q_nxt.pin = !q_r.pin;
				default: q_nxt.pin = q_r.pin;
			endcase
		end
		case (mode)
			MODE_PWM: begin
				case (ofun)
					PF_INACT: lvl = !q_r.ctrl1[C1_INIT];
					PF_ACT:   lvl = q_r.ctrl1[C1_INIT];
					PF_PWM:   lvl = pwm_act ? q_r.ctrl1[C1_INIT] : !q_r.ctrl1[C1_INIT];
					default:  lvl = !q_r.ctrl1[C1_INIT];
				endcase
				q_nxt.out = lvl ^ q_r.ctrl1[C1_POL];
			end
			MODE_CMP: q_nxt.out = q_r.pin ^ q_r.ctrl1[C1_POL];
			default:  q_nxt.out = 1'b0;
		endcase
		q_nxt.irq = |(q_nxt.status & q_nxt.mask);

		// AXI write side; address and data in either order
		wr_go = 1'b0;
		case (q_r.wst)
			WR_IDLE: begin
				if (s_axi_awvalid && !q_r.aw_got) begin
					q_nxt.aw_got = 1'b1;
					q_nxt.awaddr = s_axi_awaddr;
				end
				if (s_axi_wvalid && !q_r.w_got) begin
					q_nxt.w_got = 1'b1;
					q_nxt.wdata = s_axi_wdata;
					q_nxt.wstrb = s_axi_wstrb;
				end
				wr_go = q_r.aw_got && q_r.w_got;
				if (wr_go) begin
					q_nxt.bresp = RESP_OKAY;
					case (q_r.awaddr)
						OFS_CTRL0: q_nxt.ctrl0 = merge8(q_r.ctrl0, q_r.wdata, q_r.wstrb[0]) & 8'hf8;
						OFS_CTRL1: q_nxt.ctrl1 = merge8(q_r.ctrl1, q_r.wdata, q_r.wstrb[0]);
						OFS_ACMP: begin
							q_nxt.acmp[7:0]  = merge8(q_r.acmp[7:0], q_r.wdata, q_r.wstrb[0]);
							q_nxt.acmp[15:8] = merge8(q_r.acmp[15:8], q_r.wdata >> 8, q_r.wstrb[1]);
						end
						OFS_PCMP:   q_nxt.pcmp = merge8(q_r.pcmp, q_r.wdata, q_r.wstrb[0]);
						OFS_MASK:   if (q_r.wstrb[0]) q_nxt.mask = q_r.wdata[1:0];
						OFS_STATUS, OFS_COUNT: q_nxt.bresp = RESP_OKAY;
						default:    q_nxt.bresp = RESP_SLVERR;
					endcase
					q_nxt.aw_got = 1'b0;
					q_nxt.w_got  = 1'b0;
					q_nxt.wst    = WR_RESP;
				end
			end
			WR_RESP: if (s_axi_bready) q_nxt.wst = WR_IDLE;
			default: q_nxt.wst = WR_IDLE;
		endcase
		q_nxt.irq = |(q_nxt.status & q_nxt.mask);

		// AXI read side
		case (q_r.rst)
			RD_IDLE: begin
				if (s_axi_arvalid) begin
					q_nxt.rresp = RESP_OKAY;
					q_nxt.rdata = '0;
					case (s_axi_araddr)
						OFS_CTRL0:  q_nxt.rdata[7:0]  = q_r.ctrl0;
						OFS_CTRL1:  q_nxt.rdata[7:0]  = q_r.ctrl1;
						OFS_COUNT:  q_nxt.rdata[15:0] = q_r.cnt;
						OFS_ACMP:   q_nxt.rdata[15:0] = q_r.acmp;
						OFS_PCMP:   q_nxt.rdata[7:0]  = q_r.pcmp;
						OFS_STATUS: q_nxt.rdata[1:0]  = q_r.status;
						OFS_MASK:   q_nxt.rdata[1:0]  = q_r.mask;
						default:    q_nxt.rresp       = RESP_SLVERR;
					endcase
					q_nxt.rst = RD_DATA;
				end
			end
			RD_DATA: if (s_axi_rready) q_nxt.rst = RD_IDLE;
			default: q_nxt.rst = RD_IDLE;
		endcase

		// Handshake outputs registered from the next state, so no port sees decode logic
		q_nxt.aw_rdy = (q_nxt.wst == WR_IDLE) && !q_nxt.aw_got;
		q_nxt.w_rdy  = (q_nxt.wst == WR_IDLE) && !q_nxt.w_got;
		q_nxt.b_vld  = (q_nxt.wst == WR_RESP);
		q_nxt.ar_rdy = (q_nxt.rst == RD_IDLE);
		q_nxt.r_vld  = (q_nxt.rst == RD_DATA);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q_r        <= '0;
			q_r.wst    <= WR_IDLE;
			q_r.rst    <= RD_IDLE;
			q_r.ctrl0  <= CTRL_RESET;
			q_r.ctrl1  <= CTRL_RESET;
			q_r.pcmp   <= PCMP_ZERO;
			q_r.acmp   <= CNT_ZERO;
			q_r.cnt    <= CNT_ZERO;
			q_r.aw_rdy <= 1'b1;
			q_r.w_rdy  <= 1'b1;
			q_r.ar_rdy <= 1'b1;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign s_axi_awready = q_r.aw_rdy;
	assign s_axi_wready  = q_r.w_rdy;
	assign s_axi_bvalid  = q_r.b_vld;
	assign s_axi_bresp   = q_r.bresp;
	assign s_axi_arready = q_r.ar_rdy;
	assign s_axi_rvalid  = q_r.r_vld;
	assign s_axi_rdata   = q_r.rdata;
	assign s_axi_rresp   = q_r.rresp;
	assign timer_out     = q_r.out;
	assign irq           = q_r.irq;

	a_enable_clears: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(q_r.ctrl0[C0_ENABLE]) |=> q_r.cnt == CNT_ZERO) else $error("counter not cleared on enable");
	a_enable_init: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(q_r.ctrl0[C0_ENABLE]) |=> q_r.pin == $past(q_r.ctrl1[C1_INIT])) else $error("pin not initialised");
	a_noenable_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(!q_r.ctrl0[C0_ENABLE] && !q_r.en_d) |=> $stable(q_r.cnt)) else $error("counter moved while off");
	a_no_pflag: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode != MODE_PWM && q_r.ctrl1[C1_CLRSEL] && !q_r.status[ST_P]) |=> !q_r.status[ST_P]
		|| $past(mode) == MODE_PWM || !$past(q_r.ctrl1[C1_CLRSEL])) else $error("P flag with clear-select high");
	a_azero_noflag: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == MODE_CMP && q_r.acmp == CNT_ZERO && !q_r.status[ST_A] && q_r.wst == WR_IDLE) |=> !q_r.status[ST_A]
		|| $past(q_r.acmp) != CNT_ZERO || $past(mode) != MODE_CMP) else $error("A flag with zero compare");
	a_pin_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == MODE_CMP && !a_hit && !(enable && !q_r.en_d)) |=> $stable(q_r.pin)) else $error("pin moved without A match");
	a_tmr_out_low: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == MODE_TMR) |=> !q_r.out) else $error("pin driven in timer mode");
	a_full_duty: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == MODE_PWM && ofun == PF_PWM && duty >= period) |=> q_r.out == ($past(q_r.ctrl1[C1_INIT]) ^ $past(q_r.ctrl1[C1_POL])))
		else $error("duty above period not full");
	a_pwm_counts: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == MODE_PWM && tick && ofun == PF_INACT && period != 17'h1 && !(enable && !q_r.en_d))
		|=> q_r.cnt != $past(q_r.cnt)) else $error("PWM counter stalled while forced");

	// Period end must clear the counter and set the P flag together
	a_period_end: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == MODE_CMP && !q_r.ctrl1[C1_CLRSEL] && tick && q_r.pcmp != PCMP_ZERO
		&& q_r.cnt == {8'(q_r.pcmp - 1'b1), 8'hff} && !(enable && !q_r.en_d))
		|=> q_r.cnt == CNT_ZERO && q_r.status[ST_P]) else $error("period end not honoured");
	a_a_clears: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode != MODE_PWM && q_r.ctrl1[C1_CLRSEL] && a_hit && !(enable && !q_r.en_d)) |=> q_r.cnt == CNT_ZERO)
		else $error("counter not cleared on A match");
	a_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode != MODE_PWM && !q_r.ctrl1[C1_CLRSEL] && tick && !p_hit && !ovf && !(enable && !q_r.en_d))
		|=> q_r.cnt == 16'($past(q_r.cnt) + 1'b1)) else $error("counter did not step");
	a_pause_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(q_r.ctrl0[C0_PAUSE] && !(enable && !q_r.en_d)) |=> $stable(q_r.cnt))
		else $error("counter moved while paused");
	a_cmp_pflag: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == MODE_CMP && !q_r.ctrl1[C1_CLRSEL] && p_hit) |=> q_r.status[ST_P])
		else $error("P flag not raised");
	a_tmr_aflag: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == MODE_TMR && a_hit) |=> q_r.status[ST_A]) else $error("A flag not raised in timer mode");
	a_set_high: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == MODE_CMP && a_hit && ofun == OF_HIGH && !(enable && !q_r.en_d)) |=> q_r.pin)
		else $error("pin not set high");
	a_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == MODE_CMP && a_hit && ofun == OF_TOG && !(enable && !q_r.en_d)) |=> q_r.pin != $past(q_r.pin))
		else $error("pin not toggled");
	a_out_follows: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == MODE_CMP) |=> timer_out == ($past(q_r.pin) ^ $past(q_r.ctrl1[C1_POL])))
		else $error("pin not on output");
	a_swap_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == MODE_PWM && q_r.ctrl1[C1_SWAP] && tick && q_r.acmp != CNT_ZERO
		&& q_r.cnt == 16'(q_r.acmp - 1'b1) && !(enable && !q_r.en_d)) |=> q_r.cnt == CNT_ZERO)
		else $error("swap period wrong");
	a_pwm_pflag: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == MODE_PWM && !q_r.ctrl1[C1_SWAP] && tick && {1'b0, q_r.cnt} == 17'(period - 1'b1))
		|=> q_r.status[ST_P]) else $error("P flag not raised in PWM");
	// Handshake outputs come from flops; keep awready and arready in step with the state
	a_ready_mirror: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_awready == (q_r.wst == WR_IDLE && !q_r.aw_got) && s_axi_arready == (q_r.rst == RD_IDLE))
		else $error("ready out of step with state");

endmodule : compact_timer

`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; $display("[FAIL] %0t: got %0h exp %0h", $time, g, e); end end

module testbench;
	import compact_timer_pkg::*;

	localparam logic [31:0] RUN = (32'(CK_SYS) << C0_CLK_LO) | (32'h1 << C0_ENABLE);
	localparam logic [31:0] EXT = (32'(CK_EXTR) << C0_CLK_LO) | (32'h1 << C0_ENABLE);
	localparam logic [31:0] PAU = RUN | (32'h1 << C0_PAUSE);

	logic [ADDR_W-1:0] awaddr, araddr;
	logic [DATA_W-1:0] wdata, rdata, got, c;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp, resp;
	logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready, ext_clk_in, timer_out, irq;
	int                fails, comparisons, cnt, i;
	logic [1:0]        ofs      [4] = '{OF_NONE, OF_LOW, OF_HIGH, OF_TOG};
	logic [3:0]        ini      = 4'b0011;
	logic [1:0]        pwm_of   [7] = '{PF_PWM, PF_PWM, PF_PWM, PF_PWM, PF_PWM, PF_ACT, PF_INACT};
	logic [3:0]        pwm_bits [7] = '{4'b1001, 4'b1100, 4'b0000, 4'b1000, 4'b1010, 4'b1000, 4'b1000};
	logic [15:0]       pwm_a    [7] = '{16'h40, 16'h40, 16'h40, 16'h200, 16'h200, 16'h40, 16'h40};
	int                pwm_hi   [7] = '{256, 768, 768, 1024, 512, 1024, 0};

	compact_timer compact_timer_inst (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (awaddr),
		.s_axi_awvalid (awvalid),
		.s_axi_awready (awready),
		.s_axi_wdata   (wdata),
		.s_axi_wstrb   (wstrb),
		.s_axi_wvalid  (wvalid),
		.s_axi_wready  (wready),
		.s_axi_bresp   (bresp),
		.s_axi_bvalid  (bvalid),
		.s_axi_bready  (bready),
		.s_axi_araddr  (araddr),
		.s_axi_arvalid (arvalid),
		.s_axi_arready (arready),
		.s_axi_rdata   (rdata),
		.s_axi_rresp   (rresp),
		.s_axi_rvalid  (rvalid),
		.s_axi_rready  (rready),
		.ext_clk_in    (ext_clk_in),
		.timer_out     (timer_out),
		.irq           (irq)
	);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		got = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : rd

	// Timer stopped while reconfigured, so no match fires; timer_out still follows ctrl1 writes and, in PWM mode, acmp and pcmp writes
	task automatic cfg(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p);
		wr(OFS_CTRL0, 32'h0);
		wr(OFS_CTRL1, {24'h0, c1});
		wr(OFS_ACMP, {16'h0, a});
		wr(OFS_PCMP, {24'h0, p});
		wr(OFS_STATUS, 32'h3);
		wr(OFS_CTRL0, RUN);
	endtask : cfg

	task automatic hi_count(input int n);
		cnt = 0;
		repeat (n) begin
			@(posedge aclk);
			if (timer_out === 1'b1)
				cnt++;
		end
	endtask : hi_count

	task automatic done(input string s);
		$display("Test %s finished", s);
	endtask : done

	task automatic final_report;
		$display("Comparisons: %0d, mismatches: %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report

	// Tests need about 10k cycles
	initial begin
		repeat (40000) @(posedge aclk);
		fails++;
		final_report();
	end

	initial begin
		{awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready, ext_clk_in} = '0;
		aresetn = 1'b0;
		fails = 0;
		comparisons = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 7; i++) begin
			rd(ADDR_W'(i * 4));
			`CHK(got, 32'h0)
			`CHK(resp, RESP_OKAY)
		end
		rd(6'h1c);
		`CHK(resp, RESP_SLVERR)
		wr(6'h20, 32'h1);
		`CHK(resp, RESP_SLVERR)
		wr(OFS_COUNT, 32'h1234);
		rd(OFS_COUNT);
		`CHK(got, 32'h0)
		done("registers");
		cfg({MODE_CMP, OF_NONE, 4'b0000}, 16'h0040, 8'h01);
		repeat (600) @(posedge aclk);
		rd(OFS_COUNT);
		`CHK(got < 32'h100, 1'b1)
		rd(OFS_STATUS);
		`CHK(got, 32'h3)
		`CHK(irq, 1'b0)
		wr(OFS_MASK, 32'h2);
		repeat (2) @(posedge aclk);
		`CHK(irq, 1'b1)
		wr(OFS_CTRL0, 32'h0);
		wr(OFS_STATUS, 32'h2);
		repeat (2) @(posedge aclk);
		`CHK(irq, 1'b0)
		rd(OFS_STATUS);
		`CHK(got, 32'h1)
		wr(OFS_MASK, 32'h0);
		done("period clear and interrupt");
		cfg({MODE_CMP, OF_NONE, 4'b0001}, 16'h0180, 8'h01);
		repeat (1000) @(posedge aclk);
		rd(OFS_COUNT);
		`CHK(got <= 32'h180, 1'b1)
		rd(OFS_STATUS);
		`CHK(got, 32'h1)
		cfg({MODE_CMP, OF_NONE, 4'b0001}, 16'h0000, 8'h01);
		repeat (300) @(posedge aclk);
		rd(OFS_STATUS);
		`CHK(got, 32'h0)
		rd(OFS_COUNT);
		`CHK(got > 32'h100, 1'b1)
		done("a clear");
		for (i = 0; i < 4; i++) begin
			cfg({MODE_CMP, ofs[i], ini[i], 3'b001}, 16'h0010, 8'h00);
			repeat (3) @(posedge aclk);
			`CHK(timer_out, ini[i])
			hi_count(40);
			`CHK(cnt != (ini[i] ? 40 : 0), ofs[i] != OF_NONE)
		end
		cfg({MODE_TMR, OF_TOG, 4'b1001}, 16'h0010, 8'h00);
		hi_count(60);
		`CHK(cnt, 0)
		rd(OFS_STATUS);
		`CHK(got, 32'h1)
		done("output functions");
		for (i = 0; i < 7; i++) begin
			cfg({MODE_PWM, pwm_of[i], pwm_bits[i]}, pwm_a[i], 8'h01);
			repeat (4) @(posedge aclk);
			hi_count(1024);
			`CHK(cnt, pwm_hi[i])
		end
		rd(OFS_STATUS);
		`CHK(got, 32'h3)
		done("pwm");
		cfg({MODE_TMR, OF_NONE, 4'b0000}, 16'h0000, 8'h00);
		repeat (50) @(posedge aclk);
		wr(OFS_CTRL0, 32'h0);
		rd(OFS_COUNT);
		c = got;
		repeat (20) @(posedge aclk);
		rd(OFS_COUNT);
		`CHK(got, c)
		`CHK(c > 32'h20, 1'b1)
		wr(OFS_CTRL0, PAU);
		repeat (20) @(posedge aclk);
		rd(OFS_COUNT);
		`CHK(got, 32'h0)
		wr(OFS_CTRL0, 32'h0);
		wr(OFS_CTRL0, EXT);
		repeat (10) begin
			@(posedge aclk);
			ext_clk_in <= 1'b1;
			repeat (2) @(posedge aclk);
			ext_clk_in <= 1'b0;
			repeat (2) @(posedge aclk);
		end
		repeat (5) @(posedge aclk);
		rd(OFS_COUNT);
		`CHK(got, 32'd10)
		done("enable, pause and external clock");
		final_report();
	end
endmodule : testbench

`default_nettype wire
